// ==== src/icc_map.svh ====
// Purpose: Offsets, field positions, select codes and counts of the capture channel.
// Assumes: Included by the package and the channel top.
// Notes:   Definitions only.
`ifndef ICC_MAP_SVH
`define ICC_MAP_SVH

// Register indexes on the plain register port
`define ICC_OFS_CTRL   4'h0
`define ICC_OFS_BUF    4'h1
`define ICC_OFS_STS    4'h2
`define ICC_OFS_MSK    4'h3

// Control field positions
`define ICC_BIT_STOP   13
`define ICC_TSEL_HI    12
`define ICC_TSEL_LO    10
`define ICC_ICI_HI     6
`define ICC_ICI_LO     5
`define ICC_BIT_OV     4
`define ICC_BIT_BNE    3
`define ICC_MODE_HI    2
`define ICC_MODE_LO    0

// Time base select codes
`define ICC_TSEL_PER   3'h7
`define ICC_TSEL_EXT   3'h4
`define ICC_TSEL_T5    3'h3
`define ICC_TSEL_T4    3'h2
`define ICC_TSEL_T2    3'h1
`define ICC_TSEL_T3    3'h0

// Status and mask bit positions
`define ICC_STS_CAP    0
`define ICC_STS_OVF    1
`define ICC_STS_WAKE   2

// Buffer and prescaler figures
`define ICC_BUF_DEPTH  3'h4
`define ICC_PRE4_LAST  2'h3
`define ICC_PRE16_LAST 4'hF

`endif

// ==== src/icc_pkg.sv ====
// Purpose: Types shared by the capture channel.
// Assumes: icc_map.svh holds the numbers.
// Notes:   Mode codes follow the control register layout.
`include "icc_map.svh"

package icc_pkg;

  // Capture mode codes; 3'h2 is left unnamed
  typedef enum logic [2:0] {
    ICC_MODE_OFF    = 3'h0,
    ICC_MODE_EDGE   = 3'h1,
    ICC_MODE_FALL   = 3'h3,
    ICC_MODE_RISE4  = 3'h4,
    ICC_MODE_RISE16 = 3'h5,
    ICC_MODE_UNUSED = 3'h6,
    ICC_MODE_WAKE   = 3'h7
  } icc_mode_t;

  // Register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        write;
    logic        read;
  } icc_bus_req_t;

  // Time bases from the timers
  typedef struct packed {
    logic [15:0] twoCount;
    logic [15:0] threeCount;
    logic [15:0] fourCount;
    logic [15:0] fiveCount;
    logic [15:0] extraCount;
  } icc_tbase_t;

  // Whole state of the channel
  typedef struct packed {
    logic [2:0]        sync;
    logic              lvl;
    logic              stopIdle;
    logic [2:0]        tsel;
    logic [1:0]        captures_per_interrupt;
    icc_mode_t         mode;
    logic              ov;
    logic [3:0][15:0]  buffer;
    logic [1:0]        wp;
    logic [1:0]        rp;
    logic [2:0]        cnt;
    logic [3:0]        pre;
    logic [1:0]        icnt;
    logic [15:0]       fbCnt;
    logic [2:0]        sts;
    logic [2:0]        msk;
    logic [15:0]       rdata;
    logic              irq;
  } icc_state_t;

endpackage : icc_pkg

// ==== src/icc_input_capture_channel.sv ====
// Purpose: One input capture channel with a four-word buffer and an interrupt.
// Assumes: Timer counts arrive on clk; the capture pin is asynchronous.
// Notes:   Register port answers reads one cycle later and never stalls.
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "icc_map.svh"

module icc_input_capture_channel
  import icc_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Register port
  input  wire icc_bus_req_t busReq,
  output var  logic [15:0]  regRdata,
  // Capture pin and CPU power state
  input  wire logic         capturePin,
  input  wire logic         cpuIdle,
  input  wire logic         cpuSleep,
  // Time bases
  input  wire icc_tbase_t   timeBase,
  // Interrupt
  output var  logic         irq
);

  icc_state_t  s_q;
  icc_state_t  s_d;
  logic        riseEv;
  logic        fallEv;
  logic        capEv;
  logic        pushEv;
  logic        popEv;
  logic        capIrq;
  logic        ovEv;
  logic        wakeEv;
  logic        halted;
  logic        ctrlWrite;
  logic        ctrlRead;
  logic [1:0]  pushIdx;
  logic [15:0] tbValue;

  // Register port decode
  assign ctrlWrite = busReq.write && (busReq.addr == `ICC_OFS_CTRL);
  assign ctrlRead  = busReq.read && (busReq.addr == `ICC_OFS_CTRL);

  // Time base mux; reserved codes give zero
  always_comb begin
    unique case (s_q.tsel)
      `ICC_TSEL_PER: tbValue = s_q.fbCnt;
      `ICC_TSEL_EXT: tbValue = timeBase.extraCount;
      `ICC_TSEL_T5:  tbValue = timeBase.fiveCount;
      `ICC_TSEL_T4:  tbValue = timeBase.fourCount;
      `ICC_TSEL_T2:  tbValue = timeBase.twoCount;
      `ICC_TSEL_T3:  tbValue = timeBase.threeCount;
      default:       tbValue = 16'h0000;
    endcase
  end

  // Next state of the whole channel
  always_comb begin
    s_d     = s_q;
    riseEv  = 1'b0;
    fallEv  = 1'b0;
    capEv   = 1'b0;
    pushEv  = 1'b0;
    popEv   = 1'b0;
    capIrq  = 1'b0;
    ovEv    = 1'b0;
    wakeEv  = 1'b0;
    pushIdx = s_q.wp;
    halted  = s_q.stopIdle && cpuIdle;

    // Pin filter: a change counts once the second and third stages agree
    s_d.sync = {s_q.sync[1:0], capturePin};
    if ((s_q.sync[2] == s_q.sync[1]) && (s_q.sync[2] != s_q.lvl)) begin
      s_d.lvl = s_q.sync[2];
      riseEv  = s_q.sync[2];
      fallEv  = !s_q.sync[2];
    end

    // Free-running peripheral clock time base
    s_d.fbCnt = s_q.fbCnt + 16'h0001;

    // Control write; a mode change restarts the counters
    if (ctrlWrite) begin
      s_d.stopIdle = busReq.wdata[`ICC_BIT_STOP];
      s_d.tsel     = busReq.wdata[`ICC_TSEL_HI:`ICC_TSEL_LO];
      s_d.captures_per_interrupt      = busReq.wdata[`ICC_ICI_HI:`ICC_ICI_LO];
      s_d.mode     = icc_mode_t'(busReq.wdata[`ICC_MODE_HI:`ICC_MODE_LO]);
      // A new interrupt count must start afresh, or count 00 could skip captures
      if ((s_d.mode != s_q.mode) || (s_d.captures_per_interrupt != s_q.captures_per_interrupt)) begin
        s_d.pre  = 4'h0;
        s_d.icnt = 2'h0;
      end
      // Turning off empties the buffer and clears overflow
      if (s_d.mode == ICC_MODE_OFF) begin
        s_d.cnt = 3'h0;
        s_d.wp  = 2'h0;
        s_d.rp  = 2'h0;
        s_d.ov  = 1'b0;
      end
    end

    // Buffer read pops the oldest word
    if (busReq.read && (busReq.addr == `ICC_OFS_BUF) && (s_d.cnt != 3'h0)) begin
      popEv   = 1'b1;
      s_d.rp  = s_d.rp + 2'h1;
      s_d.cnt = s_d.cnt - 3'h1;
    end

    // Edge qualification by mode
    unique case (s_q.mode)
      ICC_MODE_EDGE: capEv = !halted && (riseEv || fallEv);
      ICC_MODE_FALL: capEv = !halted && fallEv;
      ICC_MODE_RISE4: begin
        if (!halted && riseEv) begin
          s_d.pre = s_q.pre + 4'h1;
          capEv   = (s_q.pre[1:0] == `ICC_PRE4_LAST);
        end
      end
      ICC_MODE_RISE16: begin
        if (!halted && riseEv) begin
          s_d.pre = s_q.pre + 4'h1;
          capEv   = (s_q.pre == `ICC_PRE16_LAST);
        end
      end
      // Wake pin ignores every other control bit, idle stop included
      ICC_MODE_WAKE: wakeEv = riseEv && (cpuSleep || cpuIdle);
      default: capEv = 1'b0;
    endcase

    // Push the time base, or flag overflow when full
    if (capEv) begin
      if (s_d.cnt == `ICC_BUF_DEPTH) begin
        ovEv   = 1'b1;
        s_d.ov = 1'b1;
      end else begin
        pushEv  = 1'b1;
        pushIdx = s_d.wp;
        s_d.buffer[s_d.wp] = tbValue;
        s_d.wp  = s_d.wp + 2'h1;
        s_d.cnt = s_d.cnt + 3'h1;
      end
      // Captures per interrupt; the edge mode interrupts every time
      if (s_q.mode == ICC_MODE_EDGE) begin
        capIrq = 1'b1;
      end else if (s_q.icnt == s_q.captures_per_interrupt) begin
        capIrq   = 1'b1;
        s_d.icnt = 2'h0;
      end else begin
        s_d.icnt = s_q.icnt + 2'h1;
      end
    end

    // Sticky status: write one to clear, a new event wins
    if (busReq.write && (busReq.addr == `ICC_OFS_STS)) begin
      s_d.sts = s_q.sts & ~busReq.wdata[2:0];
    end
    if (busReq.write && (busReq.addr == `ICC_OFS_MSK)) begin
      s_d.msk = busReq.wdata[2:0];
    end
    s_d.sts[`ICC_STS_CAP]  = s_d.sts[`ICC_STS_CAP] | capIrq;
    s_d.sts[`ICC_STS_OVF]  = s_d.sts[`ICC_STS_OVF] | ovEv;
    s_d.sts[`ICC_STS_WAKE] = s_d.sts[`ICC_STS_WAKE] | wakeEv;
    s_d.irq = |(s_d.sts & s_d.msk);

    // Read data stands for one cycle only
    s_d.rdata = 16'h0000;
    if (busReq.read) begin
      unique case (busReq.addr)
        `ICC_OFS_CTRL: begin
          s_d.rdata[`ICC_BIT_STOP]              = s_q.stopIdle;
          s_d.rdata[`ICC_TSEL_HI:`ICC_TSEL_LO]  = s_q.tsel;
          s_d.rdata[`ICC_ICI_HI:`ICC_ICI_LO]    = s_q.captures_per_interrupt;
          s_d.rdata[`ICC_BIT_OV]                = s_q.ov;
          s_d.rdata[`ICC_BIT_BNE]               = (s_q.cnt != 3'h0);
          s_d.rdata[`ICC_MODE_HI:`ICC_MODE_LO]  = s_q.mode;
        end
        `ICC_OFS_BUF: begin
          if (s_q.cnt != 3'h0) begin
            s_d.rdata = s_q.buffer[s_q.rp];
          end
        end
        `ICC_OFS_STS: s_d.rdata = {13'h0000, s_q.sts};
        `ICC_OFS_MSK: s_d.rdata = {13'h0000, s_q.msk};
        default:      s_d.rdata = 16'h0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign regRdata = s_q.rdata;
  assign irq      = s_q.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Capture followed by the pushed word in the buffer
  sequence s_pushSel(logic [2:0] sel);
    pushEv && (s_q.tsel == sel);
  endsequence

  sequence s_fullHit;
    capEv && (s_q.cnt == `ICC_BUF_DEPTH) && !ctrlWrite && !popEv;
  endsequence

  a_idle_halt: assert property (
    (s_q.stopIdle && cpuIdle && (s_q.mode != ICC_MODE_WAKE)) |-> !capEv)
    else $error("capture taken while halted in idle");

  a_tb_periph: assert property (
    s_pushSel(`ICC_TSEL_PER) |=> s_q.buffer[$past(pushIdx)] == $past(s_q.fbCnt))
    else $error("peripheral time base not captured");

  a_tb_timer5: assert property (
    s_pushSel(`ICC_TSEL_T5) |=> s_q.buffer[$past(pushIdx)] == $past(timeBase.fiveCount))
    else $error("timer five value not captured");

  a_tb_timer3: assert property (
    s_pushSel(`ICC_TSEL_T3) |=> s_q.buffer[$past(pushIdx)] == $past(timeBase.threeCount))
    else $error("timer three value not captured");

  a_tb_extra: assert property (
    s_pushSel(`ICC_TSEL_EXT) |=> s_q.buffer[$past(pushIdx)] == $past(timeBase.extraCount))
    else $error("further timer value not captured");

  a_ici_nth: assert property (
    (capEv && (s_q.mode != ICC_MODE_EDGE)) |-> (capIrq == (s_q.icnt == s_q.captures_per_interrupt)))
    else $error("capture interrupt at wrong count");

  a_ici_every: assert property (
    (capEv && (s_q.captures_per_interrupt == 2'h0)) |=> s_q.sts[`ICC_STS_CAP])
    else $error("count zero did not interrupt");

  a_ici_ignored: assert property (
    (capEv && (s_q.mode == ICC_MODE_EDGE)) |=> s_q.sts[`ICC_STS_CAP])
    else $error("edge mode capture gave no interrupt");

  a_ov_set: assert property (
    s_fullHit |=> s_q.ov && (s_q.cnt == `ICC_BUF_DEPTH) && s_q.sts[`ICC_STS_OVF])
    else $error("overflow not flagged when full");

  a_bne_read: assert property (
    ctrlRead |=> (regRdata[`ICC_BIT_BNE] == $past(s_q.cnt != 3'h0)))
    else $error("not-empty flag wrong");

  a_wake_only: assert property (
    (s_q.mode == ICC_MODE_WAKE) |-> !capEv && (wakeEv == (riseEv && (cpuSleep || cpuIdle))))
    else $error("wake mode misbehaves");

  a_off_quiet: assert property (
    ((s_q.mode == ICC_MODE_OFF) || (s_q.mode == ICC_MODE_UNUSED)) |-> !capEv && !wakeEv)
    else $error("disabled channel produced an event");

  a_pre_sixteen: assert property (
    ((s_q.mode == ICC_MODE_RISE16) && capEv) |-> riseEv && (s_q.pre == `ICC_PRE16_LAST))
    else $error("sixteen prescaler off");

  a_pre_four: assert property (
    ((s_q.mode == ICC_MODE_RISE4) && capEv) |-> riseEv && (s_q.pre[1:0] == `ICC_PRE4_LAST))
    else $error("four prescaler off");

  a_fall_only: assert property (
    ((s_q.mode == ICC_MODE_FALL) && !halted) |-> (capEv == fallEv))
    else $error("falling edge mode wrong");

  a_both_edges: assert property (
    ((s_q.mode == ICC_MODE_EDGE) && !halted) |-> (capEv == (riseEv || fallEv)))
    else $error("edge mode missed an edge");

  a_rsv_zero: assert property (
    ctrlRead |=> (regRdata[15:14] == 2'h0) && (regRdata[9:7] == 3'h0))
    else $error("unimplemented control bits not zero");

  a_irq_level: assert property (
    irq == |(s_q.sts & s_q.msk))
    else $error("interrupt level disagrees with status");

  // Remaining time bases, sticky flags and buffer order
  a_tb_timer4: assert property (
    s_pushSel(`ICC_TSEL_T4) |=> s_q.buffer[$past(pushIdx)] == $past(timeBase.fourCount))
    else $error("timer four value not captured");

  a_tb_timer2: assert property (
    s_pushSel(`ICC_TSEL_T2) |=> s_q.buffer[$past(pushIdx)] == $past(timeBase.twoCount))
    else $error("timer two value not captured");

  a_tb_reserved: assert property (
    (pushEv && ((s_q.tsel == 3'h5) || (s_q.tsel == 3'h6)))
      |=> (s_q.buffer[$past(pushIdx)] == 16'h0000))
    else $error("reserved time base did not capture zero");

  a_ov_sticky: assert property (
    (s_q.ov && !(ctrlWrite && (busReq.wdata[2:0] == 3'h0))) |=> s_q.ov)
    else $error("overflow flag dropped without turning off");

  a_cnt_bound: assert property (
    s_q.cnt <= `ICC_BUF_DEPTH)
    else $error("buffer count beyond depth");

  a_pop_oldest: assert property (
    popEv |=> (regRdata == $past(s_q.buffer[s_q.rp])))
    else $error("buffer read returned wrong word");

  a_wake_sticky: assert property (
    wakeEv |=> s_q.sts[`ICC_STS_WAKE])
    else $error("wake event not recorded");

  a_cap_sticky: assert property (
    (s_q.sts[`ICC_STS_CAP] && !(busReq.write && (busReq.addr == `ICC_OFS_STS)))
      |=> s_q.sts[`ICC_STS_CAP])
    else $error("capture status lost without a clear");

  a_pre_freeze: assert property (
    (halted && !ctrlWrite && (s_q.mode != ICC_MODE_WAKE)) |=> $stable(s_q.pre))
    else $error("prescaler moved while halted");

endmodule : icc_input_capture_channel
`default_nettype wire

// ==== test/icc_pin_model.sv ====
// Purpose: Drives the capture pin the way an outside signal source would.
// Assumes: Callers ask for whole levels; each level stands 9 clk cycles.
// Notes:   Long holds give the synchroniser and the capture time to settle.
`timescale 1ns/1ps
`default_nettype none
module icc_pin_model (
  // Pacing clock
  input  wire logic clk,
  // Pin level
  output var  logic pin
);
  // Pin idles low before the first edge
  initial pin = 1'b0;

  // Hold a level well past the two cycle minimum, so no edge is lost
  task automatic setLvl(input logic v);
    @(posedge clk);
    pin <= v;
    repeat (8) @(posedge clk);
  endtask : setLvl

  // Whole pulses: one rising and one falling edge each
  task automatic pulse(input int n);
    repeat (n) begin
      setLvl(1'b1);
      setLvl(1'b0);
    end
  endtask : pulse
endmodule : icc_pin_model
`default_nettype wire

// ==== test/icc_input_capture_channel_tb.sv ====
// Purpose: Self-checking bench for the input capture channel.
// Assumes: Pin edges come from icc_pin_model; timer counts are held constant except in t_tsel, which moves them on each pass.
// Notes:   Constant time bases make every captured word predictable.
`timescale 1ns/1ps
`default_nettype none
`include "icc_map.svh"
module icc_input_capture_channel_tb
  import icc_pkg::*;
;
  localparam logic [3:0] CTRL = `ICC_OFS_CTRL;
  localparam logic [3:0] BUF  = `ICC_OFS_BUF;
  localparam logic [3:0] STS  = `ICC_OFS_STS;
  localparam logic [3:0] MSK  = `ICC_OFS_MSK;

  logic         clk      = 1'b0;
  logic         rst      = 1'b1;
  icc_bus_req_t busReq   = '0;
  logic         cpuIdle  = 1'b0;
  logic         cpuSleep = 1'b0;
  icc_tbase_t   timeBase = {16'h2222, 16'h3333, 16'h4444, 16'h5555, 16'h6666};
  logic [15:0]  regRdata;
  logic         capturePin;
  logic         irq;
  int           mismatches  = 0;
  int           checks_done = 0;
  int           cycles      = 0;

  // Clock and hang guard; the tests need a few thousand cycles at most
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  icc_input_capture_channel uut (.clk(clk), .rst(rst), .busReq(busReq), .regRdata(regRdata),
    .capturePin(capturePin), .cpuIdle(cpuIdle), .cpuSleep(cpuSleep), .timeBase(timeBase),
    .irq(irq));
  icc_pin_model pinModel (.clk(clk), .pin(capturePin));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Bus cycles: strobe for one cycle, read data sampled in the cycle after
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge clk);
    busReq.write <= 1'b0;
  endtask : wr
  task automatic rdChk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    busReq <= '{addr: a, wdata: 16'h0000, write: 1'b0, read: 1'b1};
    @(posedge clk);
    busReq.read <= 1'b0;
    #1 chk(regRdata, exp);
  endtask : rdChk

  function automatic logic [15:0] ctl(input logic s, input logic [2:0] t,
                                      input logic [1:0] i, input logic [2:0] m);
    return {2'b00, s, t, 3'b000, i, 2'b00, m};
  endfunction : ctl

  task automatic t_fields();
    rdChk(CTRL, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    wr(CTRL, 16'hFFF8);
    rdChk(CTRL, 16'h3C60);
    rdChk(4'hC, 16'h0000);
    wr(CTRL, 16'h0000);
  endtask : t_fields

  // Falling edge captures under every time base select code
  task automatic t_tsel();
    logic [15:0] tbExp [7] = '{16'h3300, 16'h2200, 16'h4400, 16'h5500, 16'h6600,
                               16'h0000, 16'h0000};
    for (int t = 0; t < 7; t++) begin
      // Move every count each pass, so a wrong select cannot match by chance
      @(posedge clk);
      timeBase <= {16'h2200 | 16'(t), 16'h3300 | 16'(t), 16'h4400 | 16'(t),
                   16'h5500 | 16'(t), 16'h6600 | 16'(t)};
      wr(CTRL, ctl(1'b0, t[2:0], 2'h0, 3'h3));
      pinModel.pulse(1);
      rdChk(CTRL, ctl(1'b0, t[2:0], 2'h0, 3'h3) | 16'h0008);
      rdChk(BUF, tbExp[t] | ((t < 5) ? 16'(t) : 16'h0000));
      rdChk(CTRL, ctl(1'b0, t[2:0], 2'h0, 3'h3));
    end
    @(posedge clk);
    timeBase <= {16'h2222, 16'h3333, 16'h4444, 16'h5555, 16'h6666};
    wr(CTRL, ctl(1'b0, 3'h7, 2'h0, 3'h3));
    pinModel.pulse(2);
    @(posedge clk);
    busReq <= '{addr: BUF, wdata: 16'h0000, write: 1'b0, read: 1'b1};
    // Two reads back to back; each word stands only in the cycle after its read
    @(posedge clk);
    #1 tbExp[0] = regRdata;
    @(posedge clk);
    busReq.read <= 1'b0;
    #1 chk(regRdata - tbExp[0], 16'h0012);
  endtask : t_tsel

  task automatic t_edge();
    wr(STS, 16'h0007);
    wr(MSK, 16'h0001);
    wr(CTRL, ctl(1'b0, 3'h0, 2'h3, 3'h1));
    chk({15'h0000, irq}, 16'h0000);
    pinModel.setLvl(1'b1);
    chk({15'h0000, irq}, 16'h0001);
    rdChk(BUF, 16'h3333);
    wr(STS, 16'h0007);
    pinModel.setLvl(1'b0);
    rdChk(STS, 16'h0001);
    rdChk(BUF, 16'h3333);
    wr(STS, 16'h0007);
    rdChk(STS, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
  endtask : t_edge

  task automatic t_ici();
    for (int k = 0; k < 4; k++) begin
      wr(CTRL, 16'h0000);
      wr(STS, 16'h0007);
      wr(CTRL, ctl(1'b0, 3'h0, k[1:0], 3'h3));
      pinModel.pulse(k);
      rdChk(STS, 16'h0000);
      pinModel.pulse(1);
      rdChk(STS, 16'h0001);
    end
  endtask : t_ici

  // Five captures into four words: the last one is dropped
  task automatic t_ovf();
    wr(CTRL, 16'h0000);
    wr(STS, 16'h0007);
    wr(CTRL, 16'h0003);
    pinModel.pulse(5);
    rdChk(CTRL, 16'h001B);
    rdChk(STS, 16'h0003);
    repeat (4) rdChk(BUF, 16'h3333);
    rdChk(BUF, 16'h0000);
    rdChk(CTRL, 16'h0013);
    wr(CTRL, 16'h0000);
    rdChk(CTRL, 16'h0000);
  endtask : t_ovf

  task automatic t_pre(input logic [2:0] m, input int n);
    wr(CTRL, 16'h0000);
    wr(CTRL, ctl(1'b0, 3'h0, 2'h0, m));
    pinModel.pulse(n - 1);
    rdChk(CTRL, ctl(1'b0, 3'h0, 2'h0, m));
    pinModel.pulse(1);
    rdChk(CTRL, ctl(1'b0, 3'h0, 2'h0, m) | 16'h0008);
    rdChk(BUF, 16'h3333);
  endtask : t_pre

  task automatic t_idle();
    wr(CTRL, 16'h0000);
    wr(CTRL, ctl(1'b1, 3'h0, 2'h0, 3'h3));
    cpuIdle <= 1'b1;
    pinModel.pulse(1);
    rdChk(CTRL, ctl(1'b1, 3'h0, 2'h0, 3'h3));
    wr(CTRL, 16'h0003);
    pinModel.pulse(1);
    rdChk(CTRL, 16'h000B);
    cpuIdle <= 1'b0;
  endtask : t_idle

  task automatic t_off();
    logic [2:0] offModes [3] = '{3'h0, 3'h2, 3'h6};
    foreach (offModes[i]) begin
      wr(CTRL, 16'h0000);
      wr(CTRL, ctl(1'b0, 3'h0, 2'h0, offModes[i]));
      pinModel.pulse(1);
      rdChk(CTRL, ctl(1'b0, 3'h0, 2'h0, offModes[i]));
    end
  endtask : t_off

  // Wake pin: counts only while the CPU sleeps or idles, never fills the buffer
  task automatic t_wake();
    wr(CTRL, 16'h0000);
    wr(STS, 16'h0007);
    wr(MSK, 16'h0004);
    wr(CTRL, 16'h0007);
    pinModel.pulse(1);
    rdChk(STS, 16'h0000);
    cpuSleep <= 1'b1;
    pinModel.pulse(1);
    rdChk(STS, 16'h0004);
    chk({15'h0000, irq}, 16'h0001);
    rdChk(CTRL, 16'h0007);
    cpuSleep <= 1'b0;
  endtask : t_wake

  task automatic results();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_fields();
    t_tsel();
    t_edge();
    t_ici();
    t_ovf();
    t_pre(3'h4, 4);
    t_pre(3'h5, 16);
    t_idle();
    t_off();
    t_wake();
    results();
  end
endmodule : icc_input_capture_channel_tb
`default_nettype wire
